/* cpu_dyn_threshold_map.vh */
// Register offsets, field positions, reset values and interval counts of the CPU threshold block.
`ifndef CPU_DYN_THRESHOLD_MAP_VH
`define CPU_DYN_THRESHOLD_MAP_VH

`define ADDR_DYN_CTRL        8'h90
`define ADDR_CH0_OFFSET      8'h94
`define ADDR_CH1_OFFSET      8'h95

`define DYN_CTRL_RESET       8'h00
`define OFFSET_RESET         8'h00

`define CODE_LSB             3
`define CODE_MSB             5
`define CAPTURE_BIT          6
`define DYN_ENABLE_BIT       7
`define DYN_CTRL_WRITE_MASK  8'hf8

`define DEC_BASE_CYCLES      12'h008
`define INC_BASE_CYCLES      12'h010
`define MONITOR_CYCLES_PER_S 8

`define OFFSET_MIN           8'hc1
`define TEMP_MAX             8'h7f
`define TEMP_MIN             8'h80

`endif

/* dyn_interval_timer.v */
// Interval timer that paces threshold decreases and increases in monitoring cycles.
`timescale 1ns/10ps
`include "cpu_dyn_threshold_map.vh"

module dyn_interval_timer (
	input  wire       clock,
	input  wire       rst_n,
	input  wire       enable,
	input  wire [2:0] interval_code,
	input  wire       monitor_tick,
	output reg        decrease_due,
	output reg        increase_due
);

	reg  [11:0] dec_count;
	reg  [11:0] inc_count;
	wire [11:0] dec_limit;
	wire [11:0] inc_limit;

	// Code n gives 8 << n decrease cycles and 16 << n increase cycles; 2048 fits 12 bits.
	assign dec_limit = `DEC_BASE_CYCLES << interval_code;
	assign inc_limit = `INC_BASE_CYCLES << interval_code;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dec_count    <= 12'h000;
			inc_count    <= 12'h000;
			decrease_due <= 1'b0;
			increase_due <= 1'b0;
		end else begin
			decrease_due <= 1'b0;
			increase_due <= 1'b0;
			if (!enable) begin
				dec_count <= 12'h000;
				inc_count <= 12'h000;
			end else if (monitor_tick) begin
				// A shortened code takes effect at once: any count past the new limit fires.
				if (dec_count + 12'h001 >= dec_limit) begin
					dec_count    <= 12'h000;
					decrease_due <= 1'b1;
				end else begin
					dec_count <= dec_count + 12'h001;
				end
				if (inc_count + 12'h001 >= inc_limit) begin
					inc_count    <= 12'h000;
					increase_due <= 1'b1;
				end else begin
					inc_count <= inc_count + 12'h001;
				end
			end
		end
	end

endmodule // dyn_interval_timer

/* cpu_sensor_dynamic_threshold_cfg.v */
// Control and offset registers, offset correction, capture and dynamic threshold for CPU sensors.
//
// Functional notes
// - Control register at 0x90 resets to 0x00.
// - Bits 5:3 choose adjustment interval in cycles.
// - Decrease 8<<n cycles, increase twice that.
// - Capture bit set: overtemp copies channel-0 reading.
// - Capture bit clear: overtemp ignored, operating point kept.
// - Enable bit set: threshold adjusts dynamically.
// - Enable bit clear: programmed threshold left unchanged.
// - Lock set makes 0x90 read-only.
// - Offset at 0x94 applied to channel 0.
// - Offset at 0x95 applied to channel 1.
// - Offset spans -63 to +127 degrees.
// - Both offset registers reset to 0x00.
// - Lock set blocks offset register writes.
`timescale 1ns/10ps
`include "cpu_dyn_threshold_map.vh"

module cpu_sensor_dynamic_threshold_cfg (
	input  wire       clock,
	input  wire       rst_n,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	input  wire       config_lock,
	input  wire       overtemp_input_n,
	input  wire       monitor_tick,
	input  wire [7:0] cpu_sensor_ch0_raw,
	input  wire       cpu_sensor_ch0_valid,
	input  wire [7:0] cpu_sensor_ch1_raw,
	input  wire       cpu_sensor_ch1_valid,
	output reg  [7:0] cpu_sensor_ch0_temp,
	output reg        cpu_sensor_ch0_temp_valid,
	output reg  [7:0] cpu_sensor_ch1_temp,
	output reg        cpu_sensor_ch1_temp_valid,
	input  wire [7:0] operating_point,
	output reg  [7:0] operating_point_value,
	output reg        operating_point_load,
	input  wire [7:0] threshold_programmed,
	input  wire [7:0] zone_high_limit,
	input  wire [7:0] zone_low_limit,
	output reg  [7:0] fan_start_threshold
);

	// Control register; bits 2:0 are unused_bits and are never stored.
	reg  [7:0] dyn_ctrl;
	reg  [7:0] ch0_offset;
	reg  [7:0] ch1_offset;

	// Overtemperature pin synchroniser and edge history.
	reg        overtemp_meta;
	reg        overtemp_sync;
	reg        overtemp_prev;
	wire       overtemp_rise;

	// Lock is a level from logic in this clock domain.
	wire       write_allowed;
	wire       write_ctrl;
	wire       write_ch0;
	wire       write_ch1;

	wire [2:0] cpu_adjust_interval_code;
	wire       overtemp_capture_select;
	wire       dyn_enable;

	wire       decrease_due;
	wire       increase_due;

	reg  [7:0] next_threshold;
	reg  [7:0] next_rdata;

	// Channel inputs and offsets gathered by index so that one loop body serves both channels.
	wire [7:0] chan_raw       [0:1];
	wire [7:0] chan_offset    [0:1];
	wire [7:0] chan_corrected [0:1];

	assign cpu_adjust_interval_code = dyn_ctrl[`CODE_MSB:`CODE_LSB];
	assign overtemp_capture_select  = dyn_ctrl[`CAPTURE_BIT];
	assign dyn_enable               = dyn_ctrl[`DYN_ENABLE_BIT];

	// Sign-extended sum of a reading and an offset, saturated to the signed 8-bit range.
	function [7:0] apply_offset;
		input [7:0] raw;
		input [7:0] offset;
		reg   [7:0] eff;
		reg   [8:0] sum;
		begin
			eff = offset;
			// Offsets below the supported floor behave as the floor itself.
			if (offset[7] && (offset < `OFFSET_MIN)) begin
				eff = `OFFSET_MIN;
			end
			sum = {raw[7], raw} + {eff[7], eff};
			if (sum[8] != sum[7]) begin
				apply_offset = sum[8] ? `TEMP_MIN : `TEMP_MAX;
			end else begin
				apply_offset = sum[7:0];
			end
		end
	endfunction

	// Signed greater-than on 8-bit two's complement temperatures.
	function signed_gt;
		input [7:0] a;
		input [7:0] b;
		begin
			signed_gt = $signed(a) > $signed(b);
		end
	endfunction

	// Address decode, used by both the write path and the read path.
	function [1:0] decode_addr;
		input [7:0] addr;
		begin
			if (addr == `ADDR_DYN_CTRL) begin
				decode_addr = 2'h1;
			end else if (addr == `ADDR_CH0_OFFSET) begin
				decode_addr = 2'h2;
			end else if (addr == `ADDR_CH1_OFFSET) begin
				decode_addr = 2'h3;
			end else begin
				decode_addr = 2'h0;
			end
		end
	endfunction

	// Both channels share one correction body; a further channel would only widen the index.
	assign chan_raw[0]    = cpu_sensor_ch0_raw;
	assign chan_raw[1]    = cpu_sensor_ch1_raw;
	assign chan_offset[0] = ch0_offset;
	assign chan_offset[1] = ch1_offset;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			assign chan_corrected[ch] = apply_offset(chan_raw[ch], chan_offset[ch]);
		end
	endgenerate

	assign write_allowed = reg_write && !config_lock;
	assign write_ctrl    = write_allowed && (decode_addr(reg_addr) == 2'h1);
	assign write_ch0     = write_allowed && (decode_addr(reg_addr) == 2'h2);
	assign write_ch1     = write_allowed && (decode_addr(reg_addr) == 2'h3);

	// Register writes. A locked write is dropped silently; nothing at the port reports it.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dyn_ctrl   <= `DYN_CTRL_RESET;
			ch0_offset <= `OFFSET_RESET;
			ch1_offset <= `OFFSET_RESET;
		end else begin
			if (write_ctrl) begin
				dyn_ctrl <= reg_wdata & `DYN_CTRL_WRITE_MASK;
			end
			if (write_ch0) begin
				ch0_offset <= reg_wdata;
			end
			if (write_ch1) begin
				ch1_offset <= reg_wdata;
			end
		end
	end

	// Read data: one cycle after the read strobe, held until the next read.
	always @* begin
		case (decode_addr(reg_addr))
			2'h1: begin
				next_rdata = dyn_ctrl;
			end
			2'h2: begin
				next_rdata = ch0_offset;
			end
			2'h3: begin
				next_rdata = ch1_offset;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end
	end

	// The pin is asynchronous; edge logic looks only at the second and third stages, never at the first.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overtemp_meta <= 1'b0;
			overtemp_sync <= 1'b0;
			overtemp_prev <= 1'b0;
		end else begin
			overtemp_meta <= !overtemp_input_n;
			overtemp_sync <= overtemp_meta;
			overtemp_prev <= overtemp_sync;
		end
	end

	assign overtemp_rise = overtemp_sync && !overtemp_prev;

	// Offset correction. Every consumer downstream sees only corrected readings.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_sensor_ch0_temp       <= 8'h00;
			cpu_sensor_ch0_temp_valid <= 1'b0;
			cpu_sensor_ch1_temp       <= 8'h00;
			cpu_sensor_ch1_temp_valid <= 1'b0;
		end else begin
			cpu_sensor_ch0_temp_valid <= cpu_sensor_ch0_valid;
			cpu_sensor_ch1_temp_valid <= cpu_sensor_ch1_valid;
			if (cpu_sensor_ch0_valid) begin
				cpu_sensor_ch0_temp <= chan_corrected[0];
			end
			if (cpu_sensor_ch1_valid) begin
				cpu_sensor_ch1_temp <= chan_corrected[1];
			end
		end
	end

	// Capture on the assertion edge, so the operating point is the temperature at which
	// overtemperature began, not a value that keeps climbing while the pin stays low.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			operating_point_value <= 8'h00;
			operating_point_load  <= 1'b0;
		end else begin
			operating_point_load <= 1'b0;
			if (overtemp_rise && overtemp_capture_select) begin
				operating_point_value <= cpu_sensor_ch0_temp;
				operating_point_load  <= 1'b1;
			end
		end
	end

	dyn_interval_timer u_interval_timer (
		.clock         (clock),
		.rst_n         (rst_n),
		.enable        (dyn_enable),
		.interval_code (cpu_adjust_interval_code),
		.monitor_tick  (monitor_tick),
		.decrease_due  (decrease_due),
		.increase_due  (increase_due)
	);

	// Running hot above the operating point lowers the threshold so fans start earlier;
	// running cool below the low limit raises it again, at half the pace.
	always @* begin
		next_threshold = fan_start_threshold;
		if (!dyn_enable) begin
			next_threshold = threshold_programmed;
		end else if (decrease_due
				&& signed_gt(cpu_sensor_ch0_temp, operating_point)
				&& signed_gt(fan_start_threshold, zone_low_limit)) begin
			next_threshold = fan_start_threshold - 8'h01;
		end else if (increase_due
				&& signed_gt(zone_low_limit, cpu_sensor_ch0_temp)
				&& signed_gt(zone_high_limit, fan_start_threshold)) begin
			next_threshold = fan_start_threshold + 8'h01;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fan_start_threshold <= 8'h00;
		end else begin
			fan_start_threshold <= next_threshold;
		end
	end

endmodule // cpu_sensor_dynamic_threshold_cfg

/* cpu_threshold_checks_assertions.sv */
// Port-level checks for the CPU threshold configuration block.
`timescale 1ns/10ps
module cpu_threshold_checks (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       overtemp_input_n,
	input wire logic       cpu_sensor_ch0_valid,
	input wire logic [7:0] cpu_sensor_ch0_temp,
	input wire logic       cpu_sensor_ch0_temp_valid,
	input wire logic       cpu_sensor_ch1_valid,
	input wire logic       cpu_sensor_ch1_temp_valid,
	input wire logic [7:0] threshold_programmed,
	input wire logic       operating_point_load,
	input wire logic [7:0] operating_point_value,
	input wire logic [7:0] fan_start_threshold
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	ch0_result_a: assert property (cpu_sensor_ch0_temp_valid |-> $past(cpu_sensor_ch0_valid))
		else $error("ch0 result without request");
	ch1_result_a: assert property (cpu_sensor_ch1_valid |=> cpu_sensor_ch1_temp_valid)
		else $error("ch1 result missing");
	ch0_hold_a: assert property (!cpu_sensor_ch0_valid |=> $stable(cpu_sensor_ch0_temp))
		else $error("ch0 reading moved without request");
	load_pulse_a: assert property (operating_point_load |=> !operating_point_load)
		else $error("capture pulse too long");
	load_value_a: assert property (operating_point_load |->
		operating_point_value == $past(cpu_sensor_ch0_temp))
		else $error("captured value is not the channel 0 reading");
	// The pin is seen three edges before the pulse: two synchroniser stages and the edge stage.
	load_pin_a: assert property (operating_point_load |-> !$past(overtemp_input_n, 3))
		else $error("capture without overtemperature");
	// A dynamic change may only move one degree; anything else must be the programmed value.
	thr_step_a: assert property ($changed(fan_start_threshold) |->
		fan_start_threshold == $past(threshold_programmed) ||
		(fan_start_threshold - $past(fan_start_threshold)) inside {8'h01, 8'hff})
		else $error("threshold jumped");
	unused_zero_a: assert property (reg_read && reg_addr == 8'h90 |=> reg_rdata[2:0] == 3'h0)
		else $error("unused control bits read nonzero");
	cover property (operating_point_load);
	cover property (cpu_sensor_ch0_temp_valid);
	cover property ($changed(fan_start_threshold));
endmodule // cpu_threshold_checks

bind cpu_sensor_dynamic_threshold_cfg cpu_threshold_checks i_cpu_threshold_checks (
	.clock                     (clock),
	.rst_n                     (rst_n),
	.reg_addr                  (reg_addr),
	.reg_read                  (reg_read),
	.reg_rdata                 (reg_rdata),
	.overtemp_input_n          (overtemp_input_n),
	.cpu_sensor_ch0_valid      (cpu_sensor_ch0_valid),
	.cpu_sensor_ch0_temp       (cpu_sensor_ch0_temp),
	.cpu_sensor_ch0_temp_valid (cpu_sensor_ch0_temp_valid),
	.cpu_sensor_ch1_valid      (cpu_sensor_ch1_valid),
	.cpu_sensor_ch1_temp_valid (cpu_sensor_ch1_temp_valid),
	.threshold_programmed      (threshold_programmed),
	.operating_point_load      (operating_point_load),
	.operating_point_value     (operating_point_value),
	.fan_start_threshold       (fan_start_threshold)
);

/* cpu_sensor_dynamic_threshold_cfg_bench.sv */
// Self-checking bench for the CPU threshold configuration block.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module cpu_sensor_dynamic_threshold_cfg_bench;
	logic       clock, rst_n, reg_write, reg_read, config_lock, overtemp_input_n, monitor_tick;
	logic       cpu_sensor_ch0_valid, cpu_sensor_ch1_valid, cpu_sensor_ch0_temp_valid;
	logic       cpu_sensor_ch1_temp_valid, operating_point_load;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cpu_sensor_ch0_raw, cpu_sensor_ch1_raw;
	logic [7:0] cpu_sensor_ch0_temp, cpu_sensor_ch1_temp, operating_point, operating_point_value;
	logic [7:0] threshold_programmed, zone_high_limit, zone_low_limit, fan_start_threshold;
	int         n_mismatch, n_compared, loads, c;
	cpu_sensor_dynamic_threshold_cfg i_cpu_sensor_dynamic_threshold_cfg (
		.clock                     (clock),
		.rst_n                     (rst_n),
		.reg_addr                  (reg_addr),
		.reg_wdata                 (reg_wdata),
		.reg_write                 (reg_write),
		.reg_read                  (reg_read),
		.reg_rdata                 (reg_rdata),
		.config_lock               (config_lock),
		.overtemp_input_n          (overtemp_input_n),
		.monitor_tick              (monitor_tick),
		.cpu_sensor_ch0_raw        (cpu_sensor_ch0_raw),
		.cpu_sensor_ch0_valid      (cpu_sensor_ch0_valid),
		.cpu_sensor_ch1_raw        (cpu_sensor_ch1_raw),
		.cpu_sensor_ch1_valid      (cpu_sensor_ch1_valid),
		.cpu_sensor_ch0_temp       (cpu_sensor_ch0_temp),
		.cpu_sensor_ch0_temp_valid (cpu_sensor_ch0_temp_valid),
		.cpu_sensor_ch1_temp       (cpu_sensor_ch1_temp),
		.cpu_sensor_ch1_temp_valid (cpu_sensor_ch1_temp_valid),
		.operating_point           (operating_point),
		.operating_point_value     (operating_point_value),
		.operating_point_load      (operating_point_load),
		.threshold_programmed      (threshold_programmed),
		.zone_high_limit           (zone_high_limit),
		.zone_low_limit            (zone_low_limit),
		.fan_start_threshold       (fan_start_threshold)
	);
	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) if (operating_point_load === 1'b1) loads++;
	// Every drive lands 1 ns after an edge so the design never samples a moving input.
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1;
		step(1);
		reg_write = 0;
		// One idle edge keeps a following call from raising the strobe in the same time step.
		step(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_read = 1;
		step(1);
		reg_read = 0;
		`CHK(reg_rdata, e)
		step(1);
	endtask
	task automatic sense(input logic [7:0] r0, r1, e0, e1);
		cpu_sensor_ch0_raw = r0;
		cpu_sensor_ch1_raw = r1;
		{cpu_sensor_ch0_valid, cpu_sensor_ch1_valid} = 2'b11;
		step(1);
		{cpu_sensor_ch0_valid, cpu_sensor_ch1_valid} = 2'b00;
		`CHK(cpu_sensor_ch0_temp, e0)
		`CHK(cpu_sensor_ch1_temp, e1)
		`CHK({cpu_sensor_ch0_temp_valid, cpu_sensor_ch1_temp_valid}, 2'b11)
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			monitor_tick = 1;
			step(1);
			monitor_tick = 0;
			step(1);
		end
	endtask
	task automatic summarize;
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		summarize;
	end
	initial begin
		{rst_n, reg_write, reg_read, config_lock, monitor_tick, loads} = 0;
		{cpu_sensor_ch0_valid, cpu_sensor_ch1_valid, reg_addr, reg_wdata} = 0;
		{cpu_sensor_ch0_raw, cpu_sensor_ch1_raw, operating_point} = 0;
		overtemp_input_n = 1;
		threshold_programmed = 8'h20;
		zone_high_limit = 8'h40;
		zone_low_limit = 8'h10;
		step(10);
		rst_n = 1;
		step(1);
		rd(8'h90, 8'h00);
		rd(8'h94, 8'h00);
		rd(8'h95, 8'h00);
		wr(8'h90, 8'hff);
		rd(8'h90, 8'hf8);
		wr(8'h90, 8'h00);
		wr(8'h94, 8'hfe);
		wr(8'h95, 8'h7f);
		rd(8'h95, 8'h7f);
		sense(8'h30, 8'h10, 8'h2e, 8'h7f);
		wr(8'h94, 8'hc1);
		sense(8'h80, 8'h81, 8'h80, 8'h00);
		wr(8'h94, 8'h90);
		sense(8'h50, 8'h00, 8'h11, 8'h7f);
		wr(8'h94, 8'hfe);
		sense(8'h30, 8'h00, 8'h2e, 8'h7f);
		overtemp_input_n = 0;
		step(8);
		`CHK(loads, 0)
		overtemp_input_n = 1;
		step(4);
		wr(8'h90, 8'h40);
		overtemp_input_n = 0;
		step(8);
		`CHK(loads, 1)
		`CHK(operating_point_value, 8'h2e)
		overtemp_input_n = 1;
		// The reading sits above the operating point, so each due interval lowers by one.
		for (c = 0; c < 2; c++) begin
			wr(8'h90, {2'b10, c[2:0], 3'h0});
			tick((8 << c) - 1);
			`CHK(fan_start_threshold, 8'h20)
			tick(1);
			step(2);
			`CHK(fan_start_threshold, 8'h1f)
			wr(8'h90, 8'h00);
			step(2);
			`CHK(fan_start_threshold, 8'h20)
		end
		// A reading below the low limit raises the threshold once per increase interval.
		sense(8'h00, 8'h00, 8'hfe, 8'h7f);
		wr(8'h90, 8'h80);
		tick(15);
		`CHK(fan_start_threshold, 8'h20)
		tick(1);
		step(2);
		`CHK(fan_start_threshold, 8'h21)
		wr(8'h90, 8'h00);
		step(2);
		`CHK(fan_start_threshold, 8'h20)
		config_lock = 1;
		wr(8'h94, 8'h11);
		wr(8'h90, 8'h88);
		rd(8'h94, 8'hfe);
		rd(8'h90, 8'h00);
		summarize;
	end
endmodule // cpu_sensor_dynamic_threshold_cfg_bench
